// ==== src/lpm_pkg.sv ====
// Shared constants and types of the low-power mode controller
package lpm_pkg;
	// Power mode control register bit positions
	localparam int unsigned HALT_LO_BIT = 1;
	localparam int unsigned HALT_HI_BIT = 2;
	localparam int unsigned WATCH_N_BIT = 3;
	localparam int unsigned SWRST_N_BIT = 4;
	localparam int unsigned FLOAT_BIT = 5;
	localparam int unsigned SLEEP_BIT = 6;
	localparam int unsigned STOP_BIT = 7;
	localparam logic [7:0] PMC_RESET = 8'h18;
	// Clock select register bit positions (our choice)
	localparam int unsigned PLL_SEL_BIT = 0;
	localparam int unsigned SUB_SEL_BIT = 1;
	localparam logic [1:0] CKS_RESET = 2'h3;
	// Software reset length in machine cycles
	localparam logic [1:0] SWRST_CYCLES = 2'h3;
	// Halt cycle counts per field value
	localparam logic [3:0] HALT_CNT_0 = 4'h0;
	localparam logic [3:0] HALT_CNT_1 = 4'h1;
	localparam logic [3:0] HALT_CNT_2 = 4'h2;
	localparam logic [3:0] HALT_CNT_3 = 4'h3;
	// Register selectors on the CPU write port
	localparam logic SEL_PMC = 1'b0;
	localparam logic SEL_CKS = 1'b1;
	typedef enum logic [2:0]
	{
		LPM_RUN,
		LPM_MAIN_SLEEP,
		LPM_PLL_SLEEP,
		LPM_SUB_SLEEP,
		LPM_TIMEBASE,
		LPM_WATCH,
		LPM_STOP
	} lpm_mode_t;
endpackage

// ==== src/lpm_if.sv ====
// Interface between the mode controller and the CPU core side
`timescale 1ns/100ps
interface lpm_if;
	logic wr_en;
	logic wr_sel;
	logic [7:0] wr_data;
	logic cpu_access;
	logic irq_pending;
	logic ext_irq;
	logic watch_irq;
	logic timebase_irq;
	logic ext_reset_n;
	logic cpu_clk_en;
	logic res_clk_en;
	logic osc_run;
	logic sub_run;
	logic mach_run;
	logic timebase_run;
	logic watch_run;
	logic pins_float;
	logic pins_hold;
	logic int_reset;
	logic [7:0] pmc_read;
	lpm_pkg::lpm_mode_t mode;
	modport dev
	(
		input wr_en, wr_sel, wr_data, cpu_access, irq_pending, ext_irq, watch_irq, timebase_irq, ext_reset_n,
		output cpu_clk_en, res_clk_en, osc_run, sub_run, mach_run, timebase_run, watch_run,
		output pins_float, pins_hold, int_reset, pmc_read, mode
	);
	modport cpu
	(
		output wr_en, wr_sel, wr_data, cpu_access, irq_pending, ext_irq, watch_irq, timebase_irq, ext_reset_n,
		input cpu_clk_en, res_clk_en, osc_run, sub_run, mach_run, timebase_run, watch_run,
		input pins_float, pins_hold, int_reset, pmc_read, mode
	);
endinterface

// ==== src/lpm_device.sv ====
// Low-power mode controller: standby modes, intermittent CPU clock, software reset
`timescale 1ns/100ps
module lpm_device
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// CPU side
	lpm_if.dev bus
);
	import lpm_pkg::*;

	logic [7:0] pmc;
	logic [1:0] cks;
	lpm_mode_t mode;
	lpm_mode_t next_mode;
	logic [3:0] halt_cnt;
	logic [1:0] swrst_cnt;
	logic [3:0] halt_len;
	logic ext_rst_s1, ext_rst_s2, ext_s1, ext_s2;
	logic pmc_wr, cks_wr, wake, asleep;
	logic req_stop, req_watch, req_sleep;
	logic cpu_clk_en, res_clk_en, pins_float, pins_hold, int_reset;
	logic osc_run, sub_run, mach_run, timebase_run, watch_run;
	logic next_osc_run, next_sub_run, next_mach_run, next_timebase_run, next_watch_run;
	logic mode_rst, float_sel;

	// External pins pass two flops; the first is read by nothing else
	always_ff @(posedge ref_clk_i)
	begin
		ext_rst_s1 <= bus.ext_reset_n;
		ext_rst_s2 <= ext_rst_s1;
		ext_s1 <= bus.ext_irq;
		ext_s2 <= ext_s1;
	end

	// Write decode and request priority
	assign pmc_wr = bus.wr_en && bus.wr_sel == SEL_PMC && mode == LPM_RUN;
	assign cks_wr = bus.wr_en && bus.wr_sel == SEL_CKS && mode == LPM_RUN;
	assign req_stop = bus.wr_data[STOP_BIT];
	assign req_watch = !bus.wr_data[WATCH_N_BIT];
	assign req_sleep = bus.wr_data[SLEEP_BIT] && !bus.irq_pending;
	assign asleep = mode != LPM_RUN;

	// Pin reset and software reset force run; the float choice of a request write applies at once,
	// so the pins never show the previous choice for a cycle on entry
	assign mode_rst = !ext_rst_s2 || int_reset;
	assign float_sel = pmc_wr ? bus.wr_data[FLOAT_BIT] : pmc[FLOAT_BIT];

	// Halt length per access from the two-bit field
	assign halt_len = pmc[HALT_HI_BIT] ? (pmc[HALT_LO_BIT] ? HALT_CNT_3 : HALT_CNT_2)
		: (pmc[HALT_LO_BIT] ? HALT_CNT_1 : HALT_CNT_0);

	// Wake sources differ per mode; stop is woken by external interrupt only
	always_comb
	begin
		case (mode)
			LPM_MAIN_SLEEP, LPM_PLL_SLEEP, LPM_SUB_SLEEP: wake = bus.irq_pending || ext_s2;
			LPM_TIMEBASE: wake = ext_s2 || bus.watch_irq || bus.timebase_irq;
			LPM_WATCH: wake = ext_s2 || bus.watch_irq;
			LPM_STOP: wake = ext_s2;
			default: wake = 1'b0;
		endcase
	end

	// Mode selection on a request write
	always_comb
	begin
		next_mode = mode;
		if (mode_rst)
			next_mode = LPM_RUN;
		else if (mode == LPM_RUN && pmc_wr)
		begin
			if (req_stop)
				next_mode = LPM_STOP;
			else if (req_watch)
				next_mode = cks[SUB_SEL_BIT] ? LPM_TIMEBASE : LPM_WATCH;
			else if (req_sleep)
			begin
				if (!cks[SUB_SEL_BIT])
					next_mode = LPM_SUB_SLEEP;
				else if (cks[PLL_SEL_BIT])
					next_mode = LPM_MAIN_SLEEP;
				else
					next_mode = LPM_PLL_SLEEP;
			end
		end
		else if (asleep && wake)
			next_mode = LPM_RUN;
	end

	// Registers and mode; external reset acts like a device reset
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i || !ext_rst_s2 || int_reset)
		begin
			pmc <= PMC_RESET;
			cks <= CKS_RESET;
			mode <= LPM_RUN;
		end
		else
		begin
			mode <= next_mode;
			if (pmc_wr)
				pmc <= {1'b0, bus.wr_data[SLEEP_BIT:FLOAT_BIT], 1'b1, 1'b1, bus.wr_data[HALT_HI_BIT:0]};
			else if (asleep && wake)
				pmc <= {2'h0, pmc[FLOAT_BIT], 2'h3, pmc[HALT_HI_BIT:0]};
			if (cks_wr)
				cks <= bus.wr_data[1:0];
		end
	end

	// Software reset counter; writing one to the bit is ignored
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			swrst_cnt <= 2'h0;
		else if (pmc_wr && !bus.wr_data[SWRST_N_BIT])
			swrst_cnt <= SWRST_CYCLES;
		else if (swrst_cnt != 2'h0)
			swrst_cnt <= swrst_cnt - 2'h1;
	end

	// Intermittent halt: each access stalls the CPU clock halt_len cycles,
	// so instruction time grows by accesses times halt_len
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i || asleep)
			halt_cnt <= 4'h0;
		else if (halt_cnt != 4'h0)
			halt_cnt <= halt_cnt - 4'h1;
		else if (bus.cpu_access && cpu_clk_en)
			halt_cnt <= halt_len;
	end

	// Registered outputs
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			cpu_clk_en <= 1'b1;
			res_clk_en <= 1'b1;
			pins_float <= 1'b0;
			pins_hold <= 1'b0;
			int_reset <= 1'b0;
			osc_run <= 1'b1;
			sub_run <= 1'b1;
			mach_run <= 1'b1;
			timebase_run <= 1'b1;
			watch_run <= 1'b1;
		end
		else
		begin
			cpu_clk_en <= next_mode == LPM_RUN && !(bus.cpu_access && cpu_clk_en && halt_len != HALT_CNT_0)
				&& halt_cnt <= 4'h1;
			res_clk_en <= next_mode inside {LPM_RUN, LPM_MAIN_SLEEP, LPM_PLL_SLEEP, LPM_SUB_SLEEP};
			pins_float <= float_sel && next_mode inside {LPM_TIMEBASE, LPM_WATCH, LPM_STOP};
			pins_hold <= !float_sel && next_mode inside {LPM_TIMEBASE, LPM_WATCH, LPM_STOP};
			int_reset <= (pmc_wr && !bus.wr_data[SWRST_N_BIT]) || swrst_cnt > 2'h1;
			osc_run <= next_osc_run;
			sub_run <= next_sub_run;
			mach_run <= next_mach_run;
			timebase_run <= next_timebase_run;
			watch_run <= next_watch_run;
		end
	end

	// Clock run flags follow the mode being entered; registered so they change together with mode
	assign next_osc_run = !(next_mode inside {LPM_SUB_SLEEP, LPM_WATCH, LPM_STOP});
	assign next_sub_run = next_mode != LPM_STOP;
	assign next_mach_run = !(next_mode inside {LPM_TIMEBASE, LPM_WATCH, LPM_STOP});
	assign next_timebase_run = next_mode != LPM_WATCH && next_mode != LPM_STOP;
	assign next_watch_run = next_mode != LPM_STOP;

	// Outputs toward the CPU end
	assign bus.osc_run = osc_run;
	assign bus.sub_run = sub_run;
	assign bus.mach_run = mach_run;
	assign bus.timebase_run = timebase_run;
	assign bus.watch_run = watch_run;
	assign bus.cpu_clk_en = cpu_clk_en;
	assign bus.res_clk_en = res_clk_en;
	assign bus.pins_float = pins_float;
	assign bus.pins_hold = pins_hold;
	assign bus.int_reset = int_reset;
	assign bus.mode = mode;
	// Stop, software reset and watch bits always read as one
	assign bus.pmc_read = {1'b1, pmc[SLEEP_BIT:FLOAT_BIT], 2'h3, pmc[HALT_HI_BIT:0]};
endmodule

// ==== src/lpm_cpu_end.sv ====
// CPU-side end: issues mode and clock writes, accesses, wake inputs
`timescale 1ns/100ps
module lpm_cpu_end
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// User requests
	input wire logic wr_req_i,
	input wire logic wr_sel_i,
	input wire logic [7:0] wr_data_i,
	input wire logic access_i,
	input wire logic irq_pending_i,
	input wire logic ext_irq_i,
	input wire logic watch_irq_i,
	input wire logic timebase_irq_i,
	input wire logic ext_reset_n_i,
	// Status back to user
	output logic busy_o,
	output lpm_pkg::lpm_mode_t mode_o,
	output logic [7:0] pmc_read_o,
	// Controller side
	lpm_if.cpu bus
);
	import lpm_pkg::*;

	logic wr_en;
	logic [1:0] fence;

	// Writes are byte-wide (no odd word writes) and held off during the no-op fence
	assign wr_en = wr_req_i && fence == 2'h0 && bus.cpu_clk_en;

	// Two no-ops plus jump after each mode write
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			fence <= 2'h0;
		else if (wr_en && wr_sel_i == SEL_PMC)
			fence <= 2'h3;
		else if (fence != 2'h0 && bus.cpu_clk_en)
			fence <= fence - 2'h1;
	end

	// Status outputs from flops
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			busy_o <= 1'b0;
			mode_o <= LPM_RUN;
			pmc_read_o <= PMC_RESET;
		end
		else
		begin
			busy_o <= fence != 2'h0 || !bus.cpu_clk_en;
			mode_o <= bus.mode;
			pmc_read_o <= bus.pmc_read;
		end
	end

	// Software must clear the peripheral output before setting float and stop
	assign bus.wr_en = wr_en;
	assign bus.wr_sel = wr_sel_i;
	assign bus.wr_data = wr_data_i;
	assign bus.cpu_access = access_i && bus.cpu_clk_en;
	assign bus.irq_pending = irq_pending_i;
	assign bus.ext_irq = ext_irq_i;
	assign bus.watch_irq = watch_irq_i;
	assign bus.timebase_irq = timebase_irq_i;
	assign bus.ext_reset_n = ext_reset_n_i;
endmodule

// ==== verif/lpm_properties.sv ====
// Concurrent checks on the signals between the mode controller and the CPU end
`timescale 1ns/100ps
module lpm_properties
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// CPU requests
	input wire logic wr_en,
	input wire logic wr_sel,
	input wire logic [7:0] wr_data,
	input wire logic irq_pending,
	// Controller answers
	input wire lpm_pkg::lpm_mode_t mode,
	input wire logic osc_run,
	input wire logic sub_run,
	input wire logic mach_run,
	input wire logic timebase_run,
	input wire logic watch_run,
	input wire logic res_clk_en,
	input wire logic pins_float,
	input wire logic pins_hold,
	input wire logic int_reset,
	input wire logic [7:0] pmc_read
);
	import lpm_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Only writes taken in run mode count as requests
	wire logic pmc_wr = wr_en && wr_sel == SEL_PMC && mode == LPM_RUN;
	wire logic keep_rst = wr_data[SWRST_N_BIT];
	// Multi-step behaviours
	sequence s_stop_req;
		pmc_wr && keep_rst && wr_data[STOP_BIT];
	endsequence
	sequence s_swrst_pulse;
		int_reset [*3] ##1 !int_reset;
	endsequence
	chk_stop_first: assert property (s_stop_req |=> mode == LPM_STOP)
		else $error("stop request not obeyed");
	chk_watch_first: assert property (pmc_wr && keep_rst && !wr_data[STOP_BIT] && !wr_data[WATCH_N_BIT]
		|=> mode inside {LPM_TIMEBASE, LPM_WATCH}) else $error("watch request lost");
	chk_sleep_blocked: assert property (pmc_wr && keep_rst && wr_data[7:6] == 2'h1
		&& wr_data[WATCH_N_BIT] && irq_pending |=> mode == LPM_RUN) else $error("sleep taken with irq");
	chk_swrst_len: assert property (pmc_wr && !keep_rst |=> s_swrst_pulse)
		else $error("software reset length wrong");
	chk_stop_clocks: assert property (mode == LPM_STOP
		|-> !(osc_run || sub_run || mach_run || timebase_run || watch_run)) else $error("clock runs in stop");
	chk_watch_clocks: assert property (mode == LPM_WATCH
		|-> !osc_run && sub_run && !mach_run && watch_run && !timebase_run) else $error("watch clocks wrong");
	chk_tbase_clocks: assert property (mode == LPM_TIMEBASE
		|-> osc_run && sub_run && !mach_run && timebase_run && watch_run) else $error("timebase clocks wrong");
	chk_sleep_clocks: assert property (mode inside {LPM_MAIN_SLEEP, LPM_PLL_SLEEP, LPM_SUB_SLEEP}
		|-> osc_run == (mode != LPM_SUB_SLEEP) && sub_run && mach_run) else $error("sleep clocks wrong");
	chk_res_clock: assert property (mode == LPM_RUN && $past(mode) == LPM_RUN |-> res_clk_en)
		else $error("resource clock gated in run");
	chk_pin_float: assert property (mode == LPM_STOP && $past(mode) == LPM_STOP
		|-> pins_float == pmc_read[FLOAT_BIT] && pins_float != pins_hold) else $error("pin state wrong");
endmodule

// ==== verif/low_power_mode_controller_tb.sv ====
// Self-checking bench joining the controller and the CPU end
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t %h %h", $time, a, b); end end
module low_power_mode_controller_tb;
	import lpm_pkg::*;
	logic ref_clk_i = 0, reset_n_i = 0, wr_req_i = 0, wr_sel_i = 0, access_i = 0, irq_pending_i = 0;
	logic ext_irq_i = 0, watch_irq_i = 0, timebase_irq_i = 0, ext_reset_n_i = 1, busy_o;
	logic [7:0] wr_data_i = 8'h18, pmc_read_o, d;
	logic [1:0] cks;
	lpm_mode_t mode_o, m;
	int mismatches = 0, cmp_count = 0, n, k, w;
	lpm_if bus();
	lpm_device lpm_device_inst(.ref_clk_i, .reset_n_i, .bus(bus));
	lpm_cpu_end lpm_cpu_end_inst(.ref_clk_i, .reset_n_i, .wr_req_i, .wr_sel_i, .wr_data_i, .access_i,
		.irq_pending_i, .ext_irq_i, .watch_irq_i, .timebase_irq_i, .ext_reset_n_i, .busy_o, .mode_o,
		.pmc_read_o, .bus(bus));
	lpm_properties lpm_properties_inst(.ref_clk_i, .reset_n_i, .wr_en(bus.wr_en), .wr_sel(bus.wr_sel),
		.wr_data(bus.wr_data), .irq_pending(bus.irq_pending), .mode(bus.mode), .osc_run(bus.osc_run),
		.sub_run(bus.sub_run), .mach_run(bus.mach_run), .timebase_run(bus.timebase_run),
		.watch_run(bus.watch_run), .res_clk_en(bus.res_clk_en), .pins_float(bus.pins_float),
		.pins_hold(bus.pins_hold), .int_reset(bus.int_reset), .pmc_read(bus.pmc_read));
	// Clock
	initial
	begin
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	task cyc(int c);
		repeat (c) @(posedge ref_clk_i);
	endtask
	// One register write; waits out the busy window first
	task wr(logic s, logic [7:0] v, int t);
		n = 0;
		while (busy_o !== 1'b0 && n < 50)
		begin
			cyc(1);
			n++;
		end
		if (busy_o !== 1'b0)
			mismatches++;
		wr_sel_i <= s;
		wr_data_i <= v;
		wr_req_i <= 1;
		cyc(1);
		`CHK(bus.wr_en, 1'b1)
		wr_req_i <= 0;
		cyc(t);
	endtask
	// Held for four cycles so the two-flop synchroniser sees it
	task pulse(int s);
		irq_pending_i <= s == 0;
		ext_irq_i <= s == 1;
		watch_irq_i <= s == 2;
		timebase_irq_i <= s == 3;
		cyc(4);
		{irq_pending_i, ext_irq_i, watch_irq_i, timebase_irq_i} <= 4'h0;
		cyc(4);
	endtask
	// Mode expected from a power mode write with the priorities applied
	function lpm_mode_t em(logic [1:0] c, logic [7:0] v);
		if (v[STOP_BIT])
			return LPM_STOP;
		if (!v[WATCH_N_BIT])
			return c[SUB_SEL_BIT] ? LPM_TIMEBASE : LPM_WATCH;
		if (v[SLEEP_BIT])
			return !c[SUB_SEL_BIT] ? LPM_SUB_SLEEP : c[PLL_SEL_BIT] ? LPM_MAIN_SLEEP : LPM_PLL_SLEEP;
		return LPM_RUN;
	endfunction
	// Which wake source leaves which mode
	function logic wk(lpm_mode_t md, int s);
		case (md)
			LPM_RUN: return 1'b0;
			LPM_STOP: return s == 1;
			LPM_WATCH: return s inside {1, 2};
			LPM_TIMEBASE: return s != 0;
			default: return s < 2;
		endcase
	endfunction
	task test_done();
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial
	begin
		cyc(20000);
		mismatches++;
		test_done();
	end
	initial
	begin
		n = $urandom(99);
		cyc(20);
		reset_n_i <= 1;
		cyc(4);
		// Sleep with an interrupt already pending stays in run
		irq_pending_i <= 1;
		wr(SEL_PMC, 8'h58, 6);
		`CHK(bus.mode, LPM_RUN)
		irq_pending_i <= 0;
		// Software reset pulse length, then registers back at reset value
		wr(SEL_PMC, 8'h08, 0);
		k = 0;
		repeat (10)
		begin
			cyc(1);
			k += bus.int_reset;
		end
		`CHK(k, 3)
		`CHK(bus.pmc_read, PMC_RESET | (8'h01 << STOP_BIT))
		`CHK(pmc_read_o, PMC_RESET | (8'h01 << STOP_BIT))
		// Intermittent mode: one access halts the CPU clock for the selected count
		for (int h = 0; h < 4; h++)
		begin
			wr(SEL_PMC, 8'h18 | (h << 1), 6);
			access_i <= 1;
			cyc(1);
			access_i <= 0;
			k = 0;
			repeat (8)
			begin
				cyc(1);
				k += !bus.cpu_clk_en;
			end
			`CHK(k, h)
		end
		// External reset pin leaves timebase, watch and stop modes and restores the register
		for (int r = 0; r < 3; r++)
		begin
			cks = (r == 0) ? 2'h3 : 2'h0;
			d = (r == 2) ? 8'hB8 : 8'h30;
			wr(SEL_CKS, {6'h00, cks}, 2);
			wr(SEL_PMC, d, 6);
			`CHK(bus.mode, em(cks, d))
			`CHK(bus.pins_float, 1'b1)
			ext_reset_n_i <= 0;
			cyc(4);
			ext_reset_n_i <= 1;
			cyc(4);
			`CHK(bus.mode, LPM_RUN)
			`CHK(bus.pmc_read, PMC_RESET | (8'h01 << STOP_BIT))
		end
		// Random mode entry and wake; corners come from the random bit mix
		repeat (48)
		begin
			cks = $urandom;
			d = $urandom;
			d[SWRST_N_BIT] = 1;
			d[0] = 0;
			wr(SEL_CKS, {6'h00, cks}, 6);
			m = em(cks, d);
			wr(SEL_PMC, d, 6);
			`CHK(bus.mode, m)
			`CHK(mode_o, m)
			if (m inside {LPM_TIMEBASE, LPM_WATCH, LPM_STOP})
				`CHK(bus.pins_float, d[FLOAT_BIT])
			w = $urandom_range(3);
			pulse(w);
			`CHK(bus.mode, wk(m, w) ? LPM_RUN : m)
			pulse(1);
			`CHK(bus.mode, LPM_RUN)
			`CHK(bus.pmc_read[SLEEP_BIT], 1'b0)
		end
		test_done();
	end
endmodule
